// [verification/gpd_port_tb.sv]
/*
 * testbench: self-checking bench of the 8-pin gpio port register file.
 * Assumes gpd_pkg and gpd_port are compiled first; drives the Avalon-MM
 * slave directly and plays the pads itself, with no partner model.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // signals and bookkeeping
    // ************************************************************
    logic                  clk_sys;      // 100 MHz clock
    logic                  reset;        // sync, active high
    gpd_pkg::gpd_bus_req_t busReq;       // avalon request
    logic [31:0]           readdata;     // avalon read data
    logic                  waitrequest;  // avalon stall
    logic [7:0]            padIn;        // pad levels seen by the port
    logic [7:0]            padDrive;     // pad drive level
    logic [7:0]            padOeN;       // low while driving
    logic                  irq;          // level interrupt
    int                    errorCnt;     // mismatches seen
    int                    comparisons;  // comparisons made
    int                    cycleCnt;     // cycles since start

    // ************************************************************
    // design under test
    // ************************************************************
    gpd_port dut_u (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .busReq      (busReq),
        .readdata    (readdata),
        .waitrequest (waitrequest),
        .padIn       (padIn),
        .padDrive    (padDrive),
        .padOeN      (padOeN),
        .irq         (irq)
    );

    // clock of 10 ns period
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 5000) begin
            errorCnt = errorCnt + 1;
            completeRun();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    // verdict and end of run
    task automatic completeRun();
        if (errorCnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // compare one value, four-state exact
    task automatic checkValue(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errorCnt = errorCnt + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic busAccess(input logic [5:0] idx, input logic wr,
                             input logic [7:0] wdata, output logic [31:0] data);
        @(posedge clk_sys);
        busReq.address   <= {idx, 2'b00};
        busReq.read      <= ~wr;
        busReq.write     <= wr;
        busReq.writedata <= {24'h000000, wdata};
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        data = readdata;
        busReq.read  <= 1'b0;
        busReq.write <= 1'b0;
    endtask

    // register write
    task automatic busWrite(input logic [5:0] idx, input logic [7:0] wdata);
        logic [31:0] unused;
        busAccess(idx, 1'b1, wdata, unused);
    endtask

    // register read against an expected byte
    task automatic readCheck(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] got;
        busAccess(idx, 1'b0, 8'h00, got);
        checkValue(got, {24'h000000, exp});
    endtask

    // pad outputs against expected enable and level
    task automatic padCheck(input logic [7:0] dirExp, input logic [7:0] lvlExp);
        repeat (3) @(posedge clk_sys);
        checkValue({24'h000000, padOeN}, {24'h000000, ~dirExp});
        checkValue({24'h000000, padDrive & ~padOeN}, {24'h000000, lvlExp & dirExp});
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        reset       = 1'b1;
        busReq      = '{address: 8'h00, read: 1'b0, write: 1'b0,
                        writedata: 32'h00000000, byteenable: 4'hF};
        padIn       = 8'h00;
        errorCnt    = 0;
        comparisons = 0;
        cycleCnt    = 0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;

        // reset values of the registers at indices 0 to 9, of irq and of the pads
        padCheck(8'h00, 8'h00);
        for (int i = 0; i < 10; i++) begin
            readCheck(6'(i), 8'h00);
        end
        checkValue({31'h0, irq}, 32'h0);

        // plain write then set, clear, toggle aliases of both banks
        for (int b = 0; b < 8; b += 4) begin
            busWrite(6'(b), 8'h5A);
            busWrite(6'(b + 1), 8'h81);
            busWrite(6'(b + 2), 8'h0A);
            busWrite(6'(b + 3), 8'h0F);
            for (int k = 0; k < 4; k++) begin
                readCheck(6'(b + k), 8'hDE);
            end
        end
        padCheck(8'hDE, 8'hDE);

        // ones to sampled level flip drive level, sampled bits stay
        busWrite(gpd_pkg::IDX_SAMPLED_LEVEL, 8'h0F);
        readCheck(gpd_pkg::IDX_DRIVE_LEVEL, 8'hD1);
        readCheck(gpd_pkg::IDX_SAMPLED_LEVEL, 8'h00);
        padCheck(8'hDE, 8'hD1);

        // pads reach sampled level regardless of drive enable
        padIn <= 8'hA5;
        repeat (8) @(posedge clk_sys);
        readCheck(gpd_pkg::IDX_SAMPLED_LEVEL, 8'hA5);

        // pad 0 buffer off: its sampled bit holds at 1
        busWrite(gpd_pkg::IDX_PAD_CONTROL_BASE, 8'h04);
        padIn <= 8'h5A;
        repeat (8) @(posedge clk_sys);
        readCheck(gpd_pkg::IDX_SAMPLED_LEVEL, 8'h5B);

        // sense modes: falling, rising, both, low level; pad 5 sensing off
        busWrite(6'h11, {5'h00, gpd_pkg::MODE_FALLING});
        busWrite(6'h12, {5'h00, gpd_pkg::MODE_RISING});
        busWrite(6'h13, {5'h00, gpd_pkg::MODE_BOTH_EDGES});
        busWrite(6'h14, {5'h00, gpd_pkg::MODE_LOW_LEVEL});
        repeat (4) @(posedge clk_sys);
        busWrite(gpd_pkg::IDX_PAD_EVENT_FLAGS, 8'hFF);
        busWrite(gpd_pkg::IDX_IRQ_CLEAR, 8'hFF);
        readCheck(gpd_pkg::IDX_PAD_EVENT_FLAGS, 8'h00);
        padIn <= 8'h64;
        repeat (8) @(posedge clk_sys);
        readCheck(gpd_pkg::IDX_PAD_EVENT_FLAGS, 8'h1E);
        readCheck(gpd_pkg::IDX_IRQ_STATUS, 8'h1E);
        checkValue({31'h0, irq}, 32'h0);

        // interrupt enable, partial flag clear, status clear
        busWrite(gpd_pkg::IDX_IRQ_ENABLE, 8'h02);
        repeat (2) @(posedge clk_sys);
        checkValue({31'h0, irq}, 32'h1);
        busWrite(gpd_pkg::IDX_PAD_EVENT_FLAGS, 8'h02);
        readCheck(gpd_pkg::IDX_PAD_EVENT_FLAGS, 8'h1C);
        busWrite(gpd_pkg::IDX_IRQ_CLEAR, 8'h02);
        repeat (2) @(posedge clk_sys);
        checkValue({31'h0, irq}, 32'h0);
        readCheck(gpd_pkg::IDX_IRQ_STATUS, 8'h1C);
        readCheck(gpd_pkg::IDX_IRQ_CLEAR, 8'h00);
        readCheck(gpd_pkg::IDX_IRQ_ENABLE, 8'h02);

        // unmapped place reads zero and ignores writes
        busWrite(6'h0F, 8'hFF);
        readCheck(6'h0F, 8'h00);

        // a write with the low byte lane off is acknowledged but ignored
        busReq.byteenable <= 4'hE;
        busWrite(gpd_pkg::IDX_DRIVE_ENABLE, 8'h00);
        busReq.byteenable <= 4'hF;
        readCheck(gpd_pkg::IDX_DRIVE_ENABLE, 8'hDE);
        completeRun();
    end

endmodule

`default_nettype wire

// [verilog/gpd_pkg.sv]
/*
 * gpd_pkg: shared constants and types of the 8-pin gpio port block.
 * Assumes a 32-bit Avalon-MM master with byte addresses; each register
 * sits in one aligned word at four times its index.
 */
`default_nettype none

package gpd_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int PAD_COUNT = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int MODE_W    = 3;

    // ************************************************************
    // register indices (byte address = 4 * index)
    // ************************************************************
    localparam logic [5:0] IDX_DRIVE_ENABLE        = 6'h00;
    localparam logic [5:0] IDX_DRIVE_ENABLE_SET    = 6'h01;
    localparam logic [5:0] IDX_DRIVE_ENABLE_CLEAR  = 6'h02;
    localparam logic [5:0] IDX_DRIVE_ENABLE_TOGGLE = 6'h03;
    localparam logic [5:0] IDX_DRIVE_LEVEL         = 6'h04;
    localparam logic [5:0] IDX_DRIVE_LEVEL_SET     = 6'h05;
    localparam logic [5:0] IDX_DRIVE_LEVEL_CLEAR   = 6'h06;
    localparam logic [5:0] IDX_DRIVE_LEVEL_TOGGLE  = 6'h07;
    localparam logic [5:0] IDX_SAMPLED_LEVEL       = 6'h08;
    localparam logic [5:0] IDX_PAD_EVENT_FLAGS     = 6'h09;
    localparam logic [5:0] IDX_PAD_CONTROL_BASE    = 6'h10;  // one per pad, 0x10..0x17
    localparam logic [5:0] IDX_IRQ_STATUS          = 6'h18;
    localparam logic [5:0] IDX_IRQ_CLEAR           = 6'h19;
    localparam logic [5:0] IDX_IRQ_ENABLE          = 6'h1A;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_MODE = 3'h0;

    // ************************************************************
    // sense mode codes
    // ************************************************************
    localparam logic [2:0] MODE_SENSE_OFF  = 3'h0;  // buffer on, no events
    localparam logic [2:0] MODE_BOTH_EDGES = 3'h1;
    localparam logic [2:0] MODE_RISING     = 3'h2;
    localparam logic [2:0] MODE_FALLING    = 3'h3;
    localparam logic [2:0] MODE_BUFFER_OFF = 3'h4;  // buffer and events off
    localparam logic [2:0] MODE_LOW_LEVEL  = 3'h5;

    // avalon request bundle
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } gpd_bus_req_t;

endpackage

`default_nettype wire

// [verilog/gpd_port.sv]
/*
 * gpd_port: register file and pad data path of one 8-pin gpio port.
 * Assumes a 100 MHz clk_sys, synchronous active-high reset, an
 * Avalon-MM master that holds its request until waitrequest is low,
 * and pad inputs that are asynchronous to clk_sys.
 */
// Added by the designer: register access over Avalon-MM.
`default_nettype none

// Functional notes
// - drive-enable bit 0 turns pad driver off, 1 turns it on.
// - input buffer depends only on the pad sense mode, never on drive enable.
// - set alias write ones set drive-enable bits; zeros do nothing.
// - clear alias write ones clear drive-enable bits; zeros do nothing.
// - toggle alias write ones invert drive-enable bits; zeros do nothing.
// - reading any drive-enable alias returns the drive-enable register.
// - drive level reaches the pad only while drive enable is set.
// - driven pad is low for level 0, high for level 1.
// - level set alias ones set drive-level bits; zeros do nothing.
// - level clear alias ones clear drive-level bits; zeros do nothing.
// - level toggle alias ones invert drive-level bits; zeros do nothing.
// - reading any drive-level alias returns the drive-level register.
// - sampled level shows pad state while its input buffer is on.
// - with buffer off, sampled bit stops updating and holds.
// - writing ones to sampled level inverts drive level; sampled bits untouched.
// - flag sets on sense-mode match; write one clears, zero leaves it.
// - mode 4 kills buffer and sensing; mode 0 kills sensing only.
module gpd_port (
    input  wire logic                 clk_sys,      // 100 MHz clock
    input  wire logic                 reset,        // sync, active high
    input  wire gpd_pkg::gpd_bus_req_t busReq,      // avalon request
    output logic [31:0]               readdata,     // avalon read data
    output logic                      waitrequest,  // avalon stall
    input  wire logic [7:0]           padIn,        // pad levels in
    output logic [7:0]                padDrive,     // pad drive level
    output logic [7:0]                padOeN,       // low while driving
    output logic                      irq           // level interrupt
);

    // ************************************************************
    // decoding helpers
    // ************************************************************
    // buffer is on for every mode but buffer-off
    function automatic logic bufferOn(input logic [2:0] mode);
        return mode != gpd_pkg::MODE_BUFFER_OFF;
    endfunction

    // does a pad sample match its sense mode
    function automatic logic senseHit(input logic [2:0] mode, input logic prev,
                                      input logic cur);
        case (mode)
            gpd_pkg::MODE_BOTH_EDGES: senseHit = prev != cur;
            gpd_pkg::MODE_RISING:     senseHit = !prev && cur;
            gpd_pkg::MODE_FALLING:    senseHit = prev && !cur;
            gpd_pkg::MODE_LOW_LEVEL:  senseHit = !cur;
            default:                  senseHit = 1'b0;
        endcase
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] driveEnable_reg;
    logic [7:0] driveLevel_reg;
    logic [7:0] sampledLevel_reg;
    logic [7:0] padEventFlags_reg;
    logic [2:0] senseMode_reg [8];
    logic [7:0] irqStatus_reg;
    logic [7:0] irqEnable_reg;
    logic [7:0] syncA_reg;
    logic [7:0] syncB_reg;
    logic [7:0] syncC_reg;
    logic [7:0] padStable_reg;
    logic [7:0] padPrev_reg;
    logic       waitReq_reg;
    logic [31:0] readData_reg;
    logic [7:0] driveEnable_next;
    logic [7:0] driveLevel_next;
    logic [7:0] bufMask;
    logic [7:0] eventHit;
    logic [5:0] regIdx;
    logic [7:0] wByte;
    logic       takeWrite;
    logic       takeRead;

    // ************************************************************
    // bus decode
    // ************************************************************
    // reads sample while waitrequest is high; writes land at the edge
    // where the master sees waitrequest low, never before
    assign regIdx    = busReq.address[7:2];
    assign wByte     = busReq.writedata[7:0];
    assign takeWrite = busReq.write && !waitReq_reg && busReq.byteenable[0];
    assign takeRead  = busReq.read && waitReq_reg;

    // ************************************************************
    // drive enable and drive level next values
    // ************************************************************
    always_comb begin
        driveEnable_next = driveEnable_reg;
        driveLevel_next  = driveLevel_reg;
        if (takeWrite) begin
            case (regIdx)
                gpd_pkg::IDX_DRIVE_ENABLE:        driveEnable_next = wByte;
                gpd_pkg::IDX_DRIVE_ENABLE_SET:    driveEnable_next = driveEnable_reg | wByte;
                gpd_pkg::IDX_DRIVE_ENABLE_CLEAR:  driveEnable_next = driveEnable_reg & ~wByte;
                gpd_pkg::IDX_DRIVE_ENABLE_TOGGLE: driveEnable_next = driveEnable_reg ^ wByte;
                gpd_pkg::IDX_DRIVE_LEVEL:         driveLevel_next  = wByte;
                gpd_pkg::IDX_DRIVE_LEVEL_SET:     driveLevel_next  = driveLevel_reg | wByte;
                gpd_pkg::IDX_DRIVE_LEVEL_CLEAR:   driveLevel_next  = driveLevel_reg & ~wByte;
                gpd_pkg::IDX_DRIVE_LEVEL_TOGGLE:  driveLevel_next  = driveLevel_reg ^ wByte;
                gpd_pkg::IDX_SAMPLED_LEVEL:       driveLevel_next  = driveLevel_reg ^ wByte;
                default: begin
                end
            endcase
        end
    end

    // drive enable and drive level registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            driveEnable_reg <= gpd_pkg::RST_BYTE;
            driveLevel_reg  <= gpd_pkg::RST_BYTE;
        end else begin
            driveEnable_reg <= driveEnable_next;
            driveLevel_reg  <= driveLevel_next;
        end
    end

    // ************************************************************
    // pad outputs
    // ************************************************************
    // level held internally; pad sees it only through the enable
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            padDrive <= gpd_pkg::RST_BYTE;
            padOeN   <= 8'hFF;
        end else begin
            padDrive <= driveLevel_reg;
            padOeN   <= ~driveEnable_reg;
        end
    end

    // ************************************************************
    // per-pad sense mode
    // ************************************************************
    generate
        for (genvar p = 0; p < 8; p++) begin : g_mode
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    senseMode_reg[p] <= gpd_pkg::RST_MODE;
                end else if (takeWrite && regIdx == gpd_pkg::IDX_PAD_CONTROL_BASE + 6'(p)) begin
                    senseMode_reg[p] <= wByte[2:0];
                end
            end
            assign bufMask[p] = bufferOn(senseMode_reg[p]);
        end
    endgenerate

    // ************************************************************
    // pad input synchroniser and filter
    // ************************************************************
    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            syncA_reg     <= gpd_pkg::RST_BYTE;
            syncB_reg     <= gpd_pkg::RST_BYTE;
            syncC_reg     <= gpd_pkg::RST_BYTE;
            padStable_reg <= gpd_pkg::RST_BYTE;
            padPrev_reg   <= gpd_pkg::RST_BYTE;
        end else begin
            syncA_reg     <= padIn;
            syncB_reg     <= syncA_reg;
            syncC_reg     <= syncB_reg;
            padStable_reg <= (syncB_reg & syncC_reg) | (padStable_reg & (syncB_reg | syncC_reg));
            padPrev_reg   <= padStable_reg;
        end
    end

    // sampled level follows only pads whose buffer is on
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sampledLevel_reg <= gpd_pkg::RST_BYTE;
        end else begin
            sampledLevel_reg <= (padStable_reg & bufMask)
                              | (sampledLevel_reg & ~bufMask);
        end
    end

    // ************************************************************
    // pad events
    // ************************************************************
    generate
        for (genvar p = 0; p < 8; p++) begin : g_event
            assign eventHit[p] = bufMask[p]
                && senseHit(senseMode_reg[p], padPrev_reg[p], padStable_reg[p]);
        end
    endgenerate

    // event flags: a new hit wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            padEventFlags_reg <= gpd_pkg::RST_BYTE;
        end else if (takeWrite && regIdx == gpd_pkg::IDX_PAD_EVENT_FLAGS) begin
            padEventFlags_reg <= (padEventFlags_reg & ~wByte) | eventHit;
        end else begin
            padEventFlags_reg <= padEventFlags_reg | eventHit;
        end
    end

    // ************************************************************
    // interrupt status, enable and output
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqStatus_reg <= gpd_pkg::RST_BYTE;
        end else if (takeWrite && regIdx == gpd_pkg::IDX_IRQ_CLEAR) begin
            irqStatus_reg <= (irqStatus_reg & ~wByte) | eventHit;
        end else begin
            irqStatus_reg <= irqStatus_reg | eventHit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqEnable_reg <= gpd_pkg::RST_BYTE;
        end else if (takeWrite && regIdx == gpd_pkg::IDX_IRQ_ENABLE) begin
            irqEnable_reg <= wByte;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_reg & irqEnable_reg);
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    // one cycle of waitrequest low after each taken request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            waitReq_reg <= 1'b1;
        end else begin
            waitReq_reg <= !((busReq.read || busReq.write) && waitReq_reg);
        end
    end

    // read mux; unmapped words read as zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            readData_reg <= 32'h0000_0000;
        end else if (takeRead) begin
            readData_reg <= 32'h0000_0000;
            case (regIdx)
                gpd_pkg::IDX_DRIVE_ENABLE, gpd_pkg::IDX_DRIVE_ENABLE_SET,
                gpd_pkg::IDX_DRIVE_ENABLE_CLEAR, gpd_pkg::IDX_DRIVE_ENABLE_TOGGLE: begin
                    readData_reg[7:0] <= driveEnable_reg;
                end
                gpd_pkg::IDX_DRIVE_LEVEL, gpd_pkg::IDX_DRIVE_LEVEL_SET,
                gpd_pkg::IDX_DRIVE_LEVEL_CLEAR, gpd_pkg::IDX_DRIVE_LEVEL_TOGGLE: begin
                    readData_reg[7:0] <= driveLevel_reg;
                end
                gpd_pkg::IDX_SAMPLED_LEVEL:   readData_reg[7:0] <= sampledLevel_reg;
                gpd_pkg::IDX_PAD_EVENT_FLAGS: readData_reg[7:0] <= padEventFlags_reg;
                gpd_pkg::IDX_IRQ_STATUS:      readData_reg[7:0] <= irqStatus_reg;
                gpd_pkg::IDX_IRQ_ENABLE:      readData_reg[7:0] <= irqEnable_reg;
                default: begin
                    if (regIdx[5:3] == gpd_pkg::IDX_PAD_CONTROL_BASE[5:3]) begin
                        readData_reg[2:0] <= senseMode_reg[regIdx[2:0]];
                    end
                end
            endcase
        end
    end

    assign readdata    = readData_reg;
    assign waitrequest = waitReq_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence seqWriteAt(logic [5:0] idx);
        takeWrite && regIdx == idx;
    endsequence

    sequence seqReadAlias;
        takeRead && regIdx[5:2] == 4'h0;
    endsequence

    sequence seqReadLevel;
        takeRead && regIdx[5:2] == 4'h1;
    endsequence

    // drive enable bank
    chk_enable_plain: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_ENABLE)
        |=> driveEnable_reg == $past(wByte))
        else $error("drive enable write lost");
    chk_enable_set: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_ENABLE_SET)
        |=> driveEnable_reg == ($past(driveEnable_reg) | $past(wByte)))
        else $error("set alias wrong");
    chk_enable_clear: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_ENABLE_CLEAR)
        |=> driveEnable_reg == ($past(driveEnable_reg) & ~$past(wByte)))
        else $error("clear alias wrong");
    chk_enable_toggle: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_ENABLE_TOGGLE)
        |=> driveEnable_reg == ($past(driveEnable_reg) ^ $past(wByte)))
        else $error("toggle alias wrong");
    chk_alias_read: assert property (seqReadAlias
        |=> !waitrequest && readdata[7:0] == $past(driveEnable_reg))
        else $error("alias read not drive enable");

    // drive level bank
    chk_level_set: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_LEVEL_SET)
        |=> driveLevel_reg == ($past(driveLevel_reg) | $past(wByte)))
        else $error("level set alias wrong");
    chk_level_clear: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_LEVEL_CLEAR)
        |-> ##2 (padDrive & $past(wByte, 2)) == 8'h00)
        else $error("cleared level still driven high");
    chk_level_toggle: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_LEVEL_TOGGLE)
        |=> driveLevel_reg == ($past(driveLevel_reg) ^ $past(wByte)))
        else $error("level toggle alias wrong");
    chk_level_read: assert property (seqReadLevel
        |=> !waitrequest && readdata[7:0] == $past(driveLevel_reg))
        else $error("alias read not drive level");
    chk_sample_toggle: assert property (seqWriteAt(gpd_pkg::IDX_SAMPLED_LEVEL)
        |=> driveLevel_reg == ($past(driveLevel_reg) ^ $past(wByte)))
        else $error("sampled write did not toggle level");

    // pad outputs
    chk_dir_to_pad: assert property (seqWriteAt(gpd_pkg::IDX_DRIVE_ENABLE)
        |-> ##2 padOeN == ~$past(wByte, 2))
        else $error("pad enable does not follow drive enable write");
    chk_pad_drive: assert property (
        (padDrive & ~padOeN) == ($past(driveLevel_reg) & $past(driveEnable_reg)))
        else $error("pad level not gated by drive enable");

    // sampled level and synchroniser
    chk_sample_follow: assert property (
        ((sampledLevel_reg ^ $past(padStable_reg)) & $past(bufMask)) == 8'h00)
        else $error("sampled bit does not follow pad");
    chk_buffer_hold: assert property (
        ((sampledLevel_reg ^ $past(sampledLevel_reg)) & ~$past(bufMask)) == 8'h00)
        else $error("sampled bit moved with buffer off");
    chk_filter_agree: assert property (
        ((padStable_reg ^ $past(padStable_reg)) & ($past(syncB_reg) ^ $past(syncC_reg))) == 8'h00)
        else $error("pad level taken before stages agree");

    // event flags and interrupt status
    chk_flag_set: assert property (
        (padEventFlags_reg & $past(eventHit)) == $past(eventHit))
        else $error("event did not set flag");
    chk_flag_keep: assert property (
        !(takeWrite && regIdx == gpd_pkg::IDX_PAD_EVENT_FLAGS)
        |=> (padEventFlags_reg & $past(padEventFlags_reg)) == $past(padEventFlags_reg))
        else $error("flag fell without a clear");
    chk_flag_zero: assert property (seqWriteAt(gpd_pkg::IDX_PAD_EVENT_FLAGS)
        |=> ($past(padEventFlags_reg) & ~$past(wByte) & ~padEventFlags_reg) == 8'h00)
        else $error("zero write cleared a flag");
    chk_flag_clear: assert property (seqWriteAt(gpd_pkg::IDX_PAD_EVENT_FLAGS)
        ##0 eventHit == 8'h00 |=> (padEventFlags_reg & $past(wByte)) == 8'h00)
        else $error("flag not cleared");
    chk_sense_off: assert property (
        (senseMode_reg[0] == gpd_pkg::MODE_SENSE_OFF
         || senseMode_reg[0] == gpd_pkg::MODE_BUFFER_OFF) && !padEventFlags_reg[0]
        |=> !padEventFlags_reg[0])
        else $error("event flag set with sensing off");
    chk_status_set: assert property (
        (irqStatus_reg & $past(eventHit)) == $past(eventHit))
        else $error("event did not set status");
    chk_irq_quiet: assert property (irqEnable_reg == 8'h00 |=> !irq)
        else $error("interrupt with all sources disabled");

    // every pad in a quiet mode raises no event
    generate
        for (genvar q = 0; q < 8; q++) begin : g_quiet
            chk_quiet_pad: assert property (@(posedge clk_sys) disable iff (reset)
                (senseMode_reg[q] == gpd_pkg::MODE_SENSE_OFF
                 || senseMode_reg[q] == gpd_pkg::MODE_BUFFER_OFF) |-> !eventHit[q])
                else $error("event raised with sensing off");
        end
    endgenerate

    // bus answer
    chk_wait_answer: assert property ((busReq.read || busReq.write) && waitrequest
        |=> !waitrequest)
        else $error("request not answered in one cycle");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than a cycle");

endmodule

`default_nettype wire
